// ### hw/gpio_port_params.svh
// Constants for the general-purpose I/O port: register offsets, widths, reset values.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef GPIO_PORT_PARAMS_SVH
`define GPIO_PORT_PARAMS_SVH

`define PORT_WIDTH          8
`define ADDR_WIDTH          4
`define OFS_OUTPUT_DATA     4'h0
`define OFS_DIRECTION       4'h4
`define OFS_PIN_INPUT       4'h8
`define OFS_SPECIAL_CTRL    4'hC
`define BIT_PULLUP_DISABLE  0
`define OUTPUT_DATA_RESET   8'h00
`define DIRECTION_RESET     8'h00
`define PULLUP_DIS_RESET    1'b0

`endif

// ### hw/gpio_port_pkg.sv
// Types for the general-purpose I/O port.
// Assumes the constants header is on the include path.
`include "gpio_port_params.svh"

package gpio_port_pkg;

	typedef logic [`PORT_WIDTH-1:0] port_byte_t;

	typedef struct packed
	{
		port_byte_t output_data;
		port_byte_t direction;
		logic       pullup_disable;
		port_byte_t pin_input;
		logic [31:0] read_data;
		logic        ack;
	} port_state_t;

endpackage

// ### hw/general_purpose_io_port.sv
// One eight-pin general-purpose I/O port with a classic Wishbone register slave.
// Assumes pins arrive asynchronously; pad logic resolves the wire from the enables.
//
// Summary of operation
// - Output data, direction writable; pin input read-only
// - Global pull-up disable kills every pull-up not set by an alternate override
// - Direction one makes output, zero input
// - Input with output data one pulls up
// - Reset tri-states all pins without alternate overrides, clock or not
// - Output pin drives its output data bit
// - Register pull-up only for input, data one, enabled
// - Pin input readable whatever the direction
// - Latch transparent clock high, then flop
// - Pin change visible half to one-and-half periods
// - Written value reaches pin input one period later
// - Alternate functions leave other pins usable
// - Deep sleep clamps inputs unless exempt
`timescale 1ns/1ns
`include "gpio_port_params.svh"

module general_purpose_io_port
(
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [`ADDR_WIDTH-1:0]  wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	input  wire gpio_port_pkg::port_byte_t pin_in,
	output logic      [`PORT_WIDTH-1:0]  pin_out,
	output logic      [`PORT_WIDTH-1:0]  pin_oe,
	output logic      [`PORT_WIDTH-1:0]  pin_pullup,
	input  wire logic                    deep_sleep,
	input  wire gpio_port_pkg::port_byte_t sleep_exempt,
	input  wire gpio_port_pkg::port_byte_t alt_pullup_override_en,
	input  wire gpio_port_pkg::port_byte_t alt_pullup_override_val,
	input  wire gpio_port_pkg::port_byte_t alt_dir_override_en,
	input  wire gpio_port_pkg::port_byte_t alt_dir_override_val,
	input  wire gpio_port_pkg::port_byte_t alt_value_override_en,
	input  wire gpio_port_pkg::port_byte_t alt_value_override_val,
	output logic      [`PORT_WIDTH-1:0]  alt_digital_in
);
	import gpio_port_pkg::*;

	////////////////////////////////////////////////////////////////////////////////

	port_state_t state;
	port_state_t next_state;
	port_byte_t  sync_latch;
	port_byte_t  eff_dir;
	port_byte_t  eff_val;
	port_byte_t  input_level;
	logic        access;
	logic        write_commit;

	// Byte-lane 0 merge; unaddressed bits keep their old value
	function automatic port_byte_t merge_lane(port_byte_t old_val, logic [31:0] data,
		logic [3:0] sel);
		merge_lane = sel[0] ? data[7:0] : old_val;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pin drive and pull-up

	always_comb
	begin
		eff_dir = (alt_dir_override_en & alt_dir_override_val)
			| (~alt_dir_override_en & state.direction);
		eff_val = (alt_value_override_en & alt_value_override_val)
			| (~alt_value_override_en & state.output_data);
	end

	// Async reset clears the registers, so pins without alternate overrides float without any clock edge
	assign pin_oe  = eff_dir;
	assign pin_out = eff_val & eff_dir;
	assign pin_pullup = (alt_pullup_override_en & alt_pullup_override_val)
		| (~alt_pullup_override_en & ~state.direction & state.output_data
		& {`PORT_WIDTH{~state.pullup_disable}});

	// Sleep clamp ahead of the synchroniser, to stop floating-input current
	assign input_level = pin_in & ~({`PORT_WIDTH{deep_sleep}} & ~sleep_exempt);
	assign alt_digital_in = input_level;

	////////////////////////////////////////////////////////////////////////////////
	// Input synchroniser: latch open while clk high, flop on next rising edge

	always_latch
	begin
		if (clk)
			sync_latch = input_level;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Wishbone slave, one answer per request, acked one cycle after the strobe

	assign access = wb_cyc_i & wb_stb_i & ~state.ack;
	// Writes land on the edge that ends the ack cycle, while the request still stands
	assign write_commit = wb_cyc_i & wb_stb_i & wb_we_i & state.ack;

	always_comb
	begin
		next_state = state;
		next_state.pin_input = sync_latch;
		next_state.ack = access;
		if (write_commit)
		begin
			unique case (wb_adr_i)
				`OFS_OUTPUT_DATA:
					next_state.output_data = merge_lane(state.output_data, wb_dat_i,
						wb_sel_i);
				`OFS_DIRECTION:
					next_state.direction = merge_lane(state.direction, wb_dat_i,
						wb_sel_i);
				`OFS_SPECIAL_CTRL:
					if (wb_sel_i[0])
						next_state.pullup_disable = wb_dat_i[`BIT_PULLUP_DISABLE];
				default:
					next_state.read_data = state.read_data;
			endcase
		end
		if (access & ~wb_we_i)
		begin
			unique case (wb_adr_i)
				`OFS_OUTPUT_DATA:  next_state.read_data = {24'h000000, state.output_data};
				`OFS_DIRECTION:    next_state.read_data = {24'h000000, state.direction};
				`OFS_PIN_INPUT:    next_state.read_data = {24'h000000, state.pin_input};
				`OFS_SPECIAL_CTRL: next_state.read_data = {31'h00000000, state.pullup_disable};
				default:           next_state.read_data = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state.output_data    <= `OUTPUT_DATA_RESET;
			state.direction      <= `DIRECTION_RESET;
			state.pullup_disable <= `PULLUP_DIS_RESET;
			state.pin_input      <= 8'h00;
			state.read_data      <= 32'h00000000;
			state.ack            <= 1'b0;
		end
		else
			state <= next_state;
	end

	assign wb_dat_o = state.read_data;
	assign wb_ack_o = state.ack;

endmodule

// ### tb/port_far_side.sv
// Far-side circuitry on the port pins: outside drivers, floating pins.
// Assumes oe high means the port drives the pin.
`timescale 1ns/1ns
module port_far_side
(
	input  wire logic       clk,
	input  wire logic [7:0] oe,
	input  wire logic [7:0] drv,
	input  wire logic [7:0] pu,
	input  wire logic [7:0] ext_en,
	input  wire logic [7:0] ext,
	output logic      [7:0] pin
);
	logic [7:0] flt = 8'h55;
	// Undriven pins toggle, so a stale level never passes
	always @(posedge clk) flt <= ~flt;
	assign pin = oe & drv | ~oe & (ext_en & ext | ~ext_en & (pu | flt));
endmodule

// ### tb/gpio_port_properties.sv
// Checker for the port's bus answer and pin controls.
// Assumes alternate override values are held low.
`timescale 1ns/1ns
module gpio_port_properties
(
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [7:0]  pin_out,
	input wire logic [7:0]  pin_oe,
	input wire logic [7:0]  pin_pullup,
	input wire logic [7:0]  alt_dir_override_en
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire req = wb_cyc_i & wb_stb_i & !wb_ack_o;
	a_ack_follows: assert property (req |=> wb_ack_o) else $error("no ack");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	a_ack_unasked: assert property (!req |=> !wb_ack_o) else $error("stray ack");
	a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("upper bits set");
	a_reset_hiz: assert property (disable iff (1'b0) !reset_n |-> (pin_oe | pin_pullup) == 8'h00)
		else $error("pin active in reset");
	a_pullup_input: assert property ((pin_pullup & pin_oe) == 8'h00)
		else $error("pull-up on output");
	a_drive_output: assert property ((pin_out & ~pin_oe) == 8'h00) else $error("input driven");
	a_oe_write_only: assert property (!(wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o) ##1 $stable(alt_dir_override_en) |-> $stable(pin_oe))
		else $error("direction moved");
	c_write: cover property (req & wb_we_i);
	c_pullup: cover property (pin_pullup != 8'h00);
	c_mixed: cover property (pin_oe != 8'h00 && pin_pullup != 8'h00);
endmodule
bind general_purpose_io_port gpio_port_properties i_props(.clk(clk), .reset_n(reset_n),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
	.alt_dir_override_en(alt_dir_override_en));

// ### tb/general_purpose_io_port_test.sv
// Random port setups over the bus; pins resolved by the far-side model.
`timescale 1ns/1ns
module general_purpose_io_port_test;
	import gpio_port_pkg::*;
	logic clk = 0, reset_n = 0, cyc = 0, we = 0, ds = 0, ack, global_pullup_disable;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 0, dat, rd;
	port_byte_t ex = 0, xe = 0, ae = 0, sx = 0, po, oe, pu, pin, adi, d, r, eo, ep, m, p;
	int n_fail = 0, checks_done = 0, i;
	always #25 clk = ~clk;
	general_purpose_io_port i_general_purpose_io_port(.clk(clk), .reset_n(reset_n),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .pin_in(pin), .pin_out(po), .pin_oe(oe),
		.pin_pullup(pu), .deep_sleep(ds), .sleep_exempt(sx), .alt_pullup_override_en(ae),
		.alt_pullup_override_val(8'h00), .alt_dir_override_en(ae), .alt_dir_override_val(8'h00),
		.alt_value_override_en(ae), .alt_value_override_val(8'h00), .alt_digital_in(adi));
	port_far_side i_port_far_side(.clk(clk), .oe(oe), .drv(po), .pu(pu), .ext_en(xe), .ext(ex),
		.pin(pin));
	task report_and_stop;
		$display("fails %0d of %0d", n_fail, checks_done);
		if (n_fail == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			n_fail++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, s, e);
		end
	endtask
	task wb(input logic w, input logic [3:0] a, input logic [31:0] v);
		@(posedge clk);
		{cyc, we, adr, wd} <= {1'b1, w, a, v};
		i = 0;
		do @(posedge clk); while (ack !== 1'b1 && ++i < 20);
		rd = dat;
		cyc <= 0;
		if (i >= 20) begin n_fail++; report_and_stop; end
	endtask
	// Clamped pins read low whatever drives them
	function port_byte_t fpin(port_byte_t o, u);
		return (o & d | ~o & (xe & ex | ~xe & u)) & ~({8{ds}} & ~sx);
	endfunction
	initial
	begin
		void'($urandom(96));
		repeat (8) @(posedge clk);
		reset_n <= 1;
		chk(oe | pu, 8'h00);
		for (int k = 0; k < 30; k++)
		begin
			{d, r, global_pullup_disable} = {$urandom, $urandom};
			{ex, xe, sx, ds} <= {$urandom, $urandom};
			wb(1, 4'h4, 0);
			ae <= k < 20 ? 8'h00 : 8'($urandom);
			wb(1, 4'hC, global_pullup_disable);
			wb(1, 4'h0, d);
			wb(1, 4'h4, r);
			wb(0, 4'h8, 0);
			eo = r & ~ae;
			ep = d & ~r & ~ae & {8{~global_pullup_disable}};
			p = fpin(eo, ep);
			m = eo | xe | ep;
			chk(rd & m, p & m);
			chk(adi & m, p & m);
			chk({oe, po, pu}, {eo, d & eo, ep});
			wb(1, 4'h8, $urandom);
			wb(0, 4'h0, 0);
			chk(rd, d);
			wb(0, 4'h4, 0);
			chk(rd, r);
			wb(0, 4'hC, 0);
			chk(rd, global_pullup_disable);
			wb(0, 4'h2, 0);
			chk(rd, 0);
		end
		reset_n <= 0;
		#5 chk(oe | pu, 8'h00);
		report_and_stop;
	end
endmodule
